// ===== dv/mtp_phy_model.sv
// Behavioural external PHY: makes the MII and reference clocks, records sent bytes.
// Assumes the bench starts the clocks per mode; rx_q is read by the bench.
`default_nettype none
module mtp_phy_model (
	input wire logic mii_run_in,
	input wire logic gig_run_in,
	input wire logic col_req_in,
	input wire logic [7:0] txd_in,
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	input wire logic gtx_clk_in,
	input wire logic txc_in,
	output logic mii_tx_clk_out,
	output logic ref_clk_out,
	output logic crs_out,
	output logic col_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] rx_q [$];
	logic half = 1'b0;
	logic e;
	logic r_en;
	logic [3:0] lo;
	logic [3:0] rlo;
	// clocks per mode; the MII clock stands still while mii_run_in is low
	initial mii_tx_clk_out = 1'b0;
	initial ref_clk_out = 1'b0;
	always #40 mii_tx_clk_out = mii_run_in ? ~mii_tx_clk_out : 1'b0;
	always #4 ref_clk_out = gig_run_in ? ~ref_clk_out : 1'b0;
	assign #3 crs_out = tx_en_in;
	assign #2 col_out = col_req_in;
	// error kept with the byte, low nibble first
	always @(posedge mii_tx_clk_out)
	begin
		if (!tx_en_in)
			half = 1'b0;
		else if (!half)
		begin
			lo = txd_in[3:0];
			e = tx_er_in;
			half = 1'b1;
		end
		else
		begin
			rx_q.push_back({e | tx_er_in, txd_in[3:0], lo});
			half = 1'b0;
		end
	end
	always @(negedge gtx_clk_in)
		if (tx_en_in)
			rx_q.push_back({tx_er_in, txd_in});
	// Sampled mid-half, clear of the core edge that moves the pins
	always @(posedge txc_in)
	begin
		#20;
		r_en = tx_en_in;
		rlo = txd_in[3:0];
	end
	always @(negedge txc_in)
	begin
		#20;
		if (r_en)
			rx_q.push_back({r_en ^ tx_en_in, txd_in[3:0], rlo});
	end
endmodule : mtp_phy_model
`default_nettype wire

// ===== dv/mtp_tx_port_properties.sv
// Pin-level checks on the PHY transmit port.
// Bound to every mtp_tx_port; sees only its ports, one core clock domain.
`default_nettype none
module mtp_tx_port_properties
	import mtp_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic rgmii_strap_in,
	input wire logic link_speed_gig_in,
	input wire logic carrier_sense_in,
	input wire logic phy_reset_enable_in,
	input wire logic [2:0] gpio_dir_out_in,
	input wire logic [7:0] txd_out,
	input wire logic tx_en_out,
	input wire logic tx_er_out,
	input wire logic gtx_clk_out,
	input wire logic rgmii_txc_out,
	input wire logic carrier_sense_out,
	input wire logic [1:0] mode_out,
	input wire logic tx_busy_out,
	input wire logic tx_ready_out,
	input wire logic phy_reset_oe_out,
	input wire logic phy_power_down_pin_oe_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	a_txd_gmii_edge: assert property (mode_out == 2'h1 && $changed(txd_out) |-> $rose(gtx_clk_out))
		else $error("txd moved off the gtx rising edge");
	a_ctl_gmii_edge: assert property (mode_out == 2'h1 && ($changed(tx_en_out) ||
		$changed(tx_er_out)) |-> $rose(gtx_clk_out)) else $error("en or er moved off gtx rise");
	// Half period follows TXC_PERIOD_NS: four core cycles high
	a_gtx_half_period: assert property (disable iff (rst_in || mode_out != 2'h1)
		$rose(gtx_clk_out) |-> gtx_clk_out [*4] ##1 !gtx_clk_out) else $error("gtx half period");
	a_rgmii_upper_unused: assert property (mode_out == 2'h2 |-> txd_out[7:4] == 4'h0)
		else $error("rgmii upper data bits driven");
	a_strap_rgmii_mode: assert property ((rgmii_strap_in && !tx_busy_out) [*8]
		|-> mode_out == 2'h2) else $error("strap high without rgmii mode");
	a_speed_gmii_mode: assert property ((!rgmii_strap_in && link_speed_gig_in &&
		!tx_busy_out) [*8] |-> mode_out == 2'h1) else $error("gig speed without gmii mode");
	a_crs_sync_seen: assert property (carrier_sense_in [*6] |-> carrier_sense_out)
		else $error("carrier sense not passed on");
	a_phy_rst_float: assert property (!phy_reset_enable_in [*2] |-> !phy_reset_oe_out)
		else $error("phy reset driven while disabled");
	a_pd_pin_input: assert property (!gpio_dir_out_in[0] [*2] |-> !phy_power_down_pin_oe_out)
		else $error("power down pin driven while input");
	a_mii_clocks_low: assert property (mode_out == 2'h0 [*3] |-> !gtx_clk_out &&
		!rgmii_txc_out) else $error("own clock running in mii mode");
	cover property ($rose(gtx_clk_out) && tx_en_out);
	cover property (mode_out == 2'h2 && tx_en_out && rgmii_txc_out);
	cover property ($fell(tx_ready_out));
endmodule : mtp_tx_port_properties
bind mtp_tx_port mtp_tx_port_properties u_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.rgmii_strap_in(rgmii_strap_in), .link_speed_gig_in(link_speed_gig_in),
	.carrier_sense_in(carrier_sense_in), .phy_reset_enable_in(phy_reset_enable_in),
	.gpio_dir_out_in(gpio_dir_out_in), .txd_out(txd_out), .tx_en_out(tx_en_out),
	.tx_er_out(tx_er_out), .gtx_clk_out(gtx_clk_out), .rgmii_txc_out(rgmii_txc_out),
	.carrier_sense_out(carrier_sense_out), .mode_out(mode_out), .tx_busy_out(tx_busy_out),
	.tx_ready_out(tx_ready_out), .phy_reset_oe_out(phy_reset_oe_out),
	.phy_power_down_pin_oe_out(phy_power_down_pin_oe_out));
`default_nettype wire

// ===== dv/mtp_tx_port_tb_top.sv
// Self-checking bench for the PHY transmit port in all three modes.
// Assumes mtp_phy_model on the pins and pull-downs on the general-purpose pins.
`default_nettype none
module mtp_tx_port_tb_top;
	import mtp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic strap; logic gig; logic [1:0] mode; logic [7:0] base;} mtp_row_t;
	localparam mtp_row_t ROWS [3] = '{{1'b0, 1'b0, 2'h0, 8'h10}, {1'b0, 1'b1, 2'h1, 8'h20},
		{1'b1, 1'b0, 2'h2, 8'h30}};
	logic clk = 1'b0, rst = 1'b1, valid = 1'b0, last = 1'b0, err = 1'b0, strap = 1'b0;
	logic gig = 1'b0, mii_run = 1'b0, gig_run = 1'b0, col_req = 1'b0, rst_en = 1'b0;
	logic rst_lvl = 1'b0, rdy_n = 1'b0;
	logic [7:0] data = 8'h00;
	logic [2:0] dir = 3'h0, val = 3'h0, gstate;
	logic tx_ready, mii_clk, ref_clk, crs, col, en, er, gtx, txc, crs_o, col_o, ref_ok, busy;
	logic prst, prst_oe, pd_in, pd_out, pd_oe;
	logic [7:0] txd;
	logic [1:0] mode, aux_in, aux_out, aux_oe;
	int mismatches = 0, check_count = 0, cycles = 0, n, i;
	mtp_tx_port u_dut (.core_clk_in(clk), .rst_in(rst), .tx_data_in(data), .tx_last_in(last),
		.tx_err_in(err), .tx_valid_in(valid), .tx_ready_out(tx_ready), .rgmii_strap_in(strap),
		.link_speed_gig_in(gig), .mii_tx_clk_in(mii_clk), .gig_reference_clock_in(ref_clk),
		.carrier_sense_in(crs), .collision_in(col), .txd_out(txd), .tx_en_out(en),
		.tx_er_out(er), .gtx_clk_out(gtx), .rgmii_txc_out(txc), .carrier_sense_out(crs_o),
		.collision_out(col_o), .ref_clock_ok_out(ref_ok), .mode_out(mode), .tx_busy_out(busy),
		.phy_reset_enable_in(rst_en), .phy_reset_level_in(rst_lvl), .phy_reset_out(prst),
		.phy_reset_oe_out(prst_oe), .gpio_dir_out_in(dir), .gpio_value_in(val),
		.phy_power_down_pin_in(pd_in), .phy_power_down_pin_out(pd_out),
		.phy_power_down_pin_oe_out(pd_oe), .aux_gpio_pin_in(aux_in), .aux_gpio_pin_out(aux_out),
		.aux_gpio_pin_oe_out(aux_oe), .gpio_state_out(gstate));
	mtp_phy_model u_phy (.mii_run_in(mii_run), .gig_run_in(gig_run), .col_req_in(col_req),
		.txd_in(txd), .tx_en_in(en), .tx_er_in(er), .gtx_clk_in(gtx), .txc_in(txc),
		.mii_tx_clk_out(mii_clk), .ref_clk_out(ref_clk), .crs_out(crs), .col_out(col));
	// Pull-downs win wherever nobody drives
	assign pd_in = pd_oe & pd_out;
	assign aux_in = aux_oe & aux_out;
	always #5 clk = ~clk;
	always @(negedge clk) rdy_n <= tx_ready;
	task automatic final_report;
	begin
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask : final_report
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
	begin
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	end
	endtask : chk
	// Offer one word and hold it until the edge that takes it
	task automatic push(input logic e, input logic l, input logic [7:0] d);
	begin
		valid <= 1'b1;
		err <= e;
		last <= l;
		data <= d;
		do
			@(posedge clk);
		while (!rdy_n);
	end
	endtask : push
	task automatic wait_rx(input int cnt);
	begin
		for (i = 0; i < 3000 && u_phy.rx_q.size() < cnt; i++)
			@(posedge clk);
		repeat (20) @(posedge clk);
	end
	endtask : wait_rx
	initial
	begin
		repeat (16) @(posedge clk);
		chk("phy_reset_oe", 10'h0, 10'(prst_oe));
		chk("pd_oe", 10'h0, 10'(pd_oe));
		chk("ready_rst", 10'h0, 10'(tx_ready));
		rst <= 1'b0;
		foreach (ROWS[r])
		begin
			strap <= ROWS[r].strap;
			gig <= ROWS[r].gig;
			gig_run <= ROWS[r].mode != 2'h0;
			mii_run <= ROWS[r].mode == 2'h0;
			repeat (20) @(posedge clk);
			chk("mode", 10'(ROWS[r].mode), 10'(mode));
			chk("ref_ok", 10'(gig_run), 10'(ref_ok));
			u_phy.rx_q.delete();
			push(1'b0, 1'b0, ROWS[r].base);
			push(1'b1, 1'b0, ROWS[r].base + 8'h1);
			push(1'b0, 1'b1, ROWS[r].base + 8'h2);
			valid <= 1'b0;
			wait_rx(3);
			chk("rx_count", 10'h3, 10'(u_phy.rx_q.size()));
			for (n = 0; n < 3; n++)
				chk("rx_word", {1'b0, n == 1, ROWS[r].base + 8'(n)}, 10'(u_phy.rx_q[n]));
			chk("idle", 10'h0, {en, er, txd});
		end
		col_req <= 1'b1;
		repeat (8) @(posedge clk);
		chk("collision", 10'h1, 10'(col_o));
		col_req <= 1'b0;
		strap <= 1'b0;
		gig_run <= 1'b0;
		mii_run <= 1'b0;
		repeat (20) @(posedge clk);
		u_phy.rx_q.delete();
		// With the PHY clock stopped nothing drains
		valid <= 1'b1;
		last <= 1'b1;
		err <= 1'b0;
		data <= 8'ha5;
		n = 0;
		repeat (24)
		begin
			@(posedge clk);
			if (rdy_n)
				n++;
		end
		valid <= 1'b0;
		chk("fifo_taken", 10'h10, 10'(n));
		mii_run <= 1'b1;
		wait_rx(16);
		chk("drained", 10'h10, 10'(u_phy.rx_q.size()));
		chk("drained_word", 10'h0a5, 10'(u_phy.rx_q[15]));
		chk("ready_again", 10'h1, 10'(tx_ready));
		dir <= 3'h5;
		val <= 3'h5;
		rst_en <= 1'b1;
		rst_lvl <= 1'b1;
		repeat (8) @(posedge clk);
		chk("phy_reset_pin", 10'h3, {8'h0, prst_oe, prst});
		chk("gpio_oe", 10'h5, {7'h0, aux_oe, pd_oe});
		chk("gpio_state", 10'h5, 10'(gstate));
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("phy_reset_oe_rst", 10'h0, 10'(prst_oe));
		chk("gpio_oe_rst", 10'h0, {7'h0, aux_oe, pd_oe});
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule : mtp_tx_port_tb_top
`default_nettype wire

// ===== pkg/mtp_pkg.sv
// Constants and types shared by the PHY transmit port block.
// Assumes a single 100 MHz core clock domain; all link pins are sampled in it.
`default_nettype none
package mtp_pkg;
	localparam int CORE_PERIOD_NS = 10;
	// Period of the self-made GMII/RGMII transmit clock
	localparam int TXC_PERIOD_NS = 80;
	// Half period in core cycles, rounded down, never below one
	localparam int TXC_HALF_CYC_I = (TXC_PERIOD_NS / (2 * CORE_PERIOD_NS)) < 1 ? 1 :
		(TXC_PERIOD_NS / (2 * CORE_PERIOD_NS));
	localparam logic [2:0] TXC_HALF_LAST = 3'(TXC_HALF_CYC_I - 1);
	// Reference clock counts as lost after this many nanoseconds without an edge
	localparam int REF_WATCH_NS = 640;
	localparam logic [6:0] REF_WATCH_CYC = 7'(REF_WATCH_NS / CORE_PERIOD_NS);
	localparam int FIFO_WIDTH = 10;
	localparam int FIFO_DEPTH = 16;
	localparam int WORD_LAST_BIT = 8;
	localparam int WORD_ERR_BIT = 9;
	// Positions in the synchronised input vector
	localparam int SY_CRS = 0;
	localparam int SY_COL = 1;
	localparam int SY_TXCLK = 2;
	localparam int SY_REF = 3;
	localparam int SY_STRAP = 4;
	localparam int SY_GPIO = 5;
	localparam int SY_WIDTH = 8;
	localparam logic [2:0] GPIO_OE_RST = 3'h0;
	localparam logic [2:0] GPIO_VAL_RST = 3'h0;
	localparam logic PHY_RST_OE_RST = 1'b0;
	localparam logic [7:0] TXD_RST = 8'h00;
	typedef enum logic [1:0] {MTP_MII, MTP_GMII, MTP_RGMII} mtp_mode_t;
	typedef enum logic [1:0] {TX_WAIT, TX_MII_HI, TX_DDR_HI} mtp_tx_state_t;
endpackage : mtp_pkg
`default_nettype wire

// ===== pkg/mtp_stream_if.sv
// Byte stream from the transmit FIFO to the PHY port logic.
// Assumes both ends run on the core clock.
`default_nettype none
interface mtp_stream_if;
	logic [9:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : mtp_stream_if
`default_nettype wire

// ===== verilog/mtp_fifo.sv
// Transmit word FIFO with valid/ready on both sides.
// Assumes writer and reader share the core clock.
`default_nettype none
module mtp_fifo
	import mtp_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	mtp_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW-1:0] nxt_wr_ptr;
	logic [AW-1:0] nxt_rd_ptr;
	logic [AW:0] nxt_count;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = rd.valid && rd.ready;
	assign rd.valid = (count_ff != '0);
	assign rd.data = mem[rd_ptr_ff];

	always_comb
	begin
		nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
		nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = (AW+1)'(count_ff + 1'b1);
		else if (pop && !push)
			nxt_count = (AW+1)'(count_ff - 1'b1);
	end

	// Ready is registered, so it looks one word ahead at the next count
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_out <= 1'b0;
		end
		else
		begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
			in_ready_out <= (nxt_count != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data_in;
	end
endmodule : mtp_fifo
`default_nettype wire

// ===== verilog/mtp_sync.sv
// Three-stage synchroniser for pins that arrive from outside the core clock.
// A change is accepted once the second and third stages agree.
`default_nettype none
module mtp_sync
	import mtp_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] nxt_sync;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			assign nxt_sync[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : sync_out[i];
		end
	endgenerate

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			sync_out <= nxt_sync;
		end
	end
endmodule : mtp_sync
`default_nettype wire

// ===== verilog/mtp_tx_port.sv
// Transmit side of the MII/GMII/RGMII PHY port, with PHY reset and GPIO pins.
// Assumes the MAC core feeds bytes on the core clock; all PHY pins are async.
// on the falling edge.
`default_nettype none
module mtp_tx_port
	import mtp_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_last_in,
	input wire logic tx_err_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	input wire logic rgmii_strap_in,
	input wire logic link_speed_gig_in,
	input wire logic mii_tx_clk_in,
	input wire logic gig_reference_clock_in,
	input wire logic carrier_sense_in,
	input wire logic collision_in,
	output logic [7:0] txd_out,
	output logic tx_en_out,
	output logic tx_er_out,
	output logic gtx_clk_out,
	output logic rgmii_txc_out,
	output logic carrier_sense_out,
	output logic collision_out,
	output logic ref_clock_ok_out,
	output logic [1:0] mode_out,
	output logic tx_busy_out,
	input wire logic phy_reset_enable_in,
	input wire logic phy_reset_level_in,
	output logic phy_reset_out,
	output logic phy_reset_oe_out,
	input wire logic [2:0] gpio_dir_out_in,
	input wire logic [2:0] gpio_value_in,
	input wire logic phy_power_down_pin_in,
	output logic phy_power_down_pin_out,
	output logic phy_power_down_pin_oe_out,
	input wire logic [1:0] aux_gpio_pin_in,
	output logic [1:0] aux_gpio_pin_out,
	output logic [1:0] aux_gpio_pin_oe_out,
	output logic [2:0] gpio_state_out
);
	logic [SY_WIDTH-1:0] sync_vec;
	logic [WORD_LAST_BIT-1:0] pop_byte;
	logic pop_last;
	logic pop_err;

	mtp_stream_if fifo_rd ();

	mtp_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.in_data_in({tx_err_in, tx_last_in, tx_data_in}),
		.in_valid_in(tx_valid_in),
		.in_ready_out(tx_ready_out),
		.rd(fifo_rd.src)
	);

	mtp_sync #(
		.WIDTH(SY_WIDTH)
	) u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.async_in({aux_gpio_pin_in, phy_power_down_pin_in, rgmii_strap_in,
			gig_reference_clock_in, mii_tx_clk_in, collision_in, carrier_sense_in}),
		.sync_out(sync_vec)
	);

	assign pop_byte = fifo_rd.data[WORD_LAST_BIT-1:0];
	assign pop_last = fifo_rd.data[WORD_LAST_BIT];
	assign pop_err = fifo_rd.data[WORD_ERR_BIT];

	// Mode selection
	mtp_mode_t mode_ff;
	mtp_mode_t nxt_mode;
	mtp_mode_t want_mode;

	always_comb
	begin
		if (sync_vec[SY_STRAP])
			want_mode = MTP_RGMII;
		else if (link_speed_gig_in)
			want_mode = MTP_GMII;
		else
			want_mode = MTP_MII;
	end

	// Clock generation and edge finding
	logic txclk_prev_ff;
	logic [2:0] div_cnt_ff;
	logic div_clk_ff;
	logic [2:0] nxt_div_cnt;
	logic nxt_div_clk;
	logic mii_rise;
	logic gen_rise;
	logic gen_fall;
	logic rise_tick;
	logic div_wrap;

	assign div_wrap = (div_cnt_ff == TXC_HALF_LAST);
	assign mii_rise = sync_vec[SY_TXCLK] && !txclk_prev_ff;
	assign gen_rise = (mode_ff != MTP_MII) && div_wrap && !div_clk_ff;
	assign gen_fall = (mode_ff != MTP_MII) && div_wrap && div_clk_ff;
	assign rise_tick = (mode_ff == MTP_MII) ? mii_rise : gen_rise;

	always_comb
	begin
		nxt_div_cnt = div_cnt_ff;
		nxt_div_clk = div_clk_ff;
		if (mode_ff == MTP_MII)
		begin
			nxt_div_cnt = '0;
			nxt_div_clk = 1'b0;
		end
		else if (div_wrap)
		begin
			nxt_div_cnt = '0;
			nxt_div_clk = !div_clk_ff;
		end
		else
		begin
			nxt_div_cnt = 3'(div_cnt_ff + 1'b1);
		end
	end

	// Transmit sequencer
	mtp_tx_state_t st_ff;
	mtp_tx_state_t nxt_st;
	logic [7:0] hold_ff;
	logic hold_err_ff;
	logic hold_last_ff;
	logic in_frame_ff;
	logic [7:0] nxt_hold;
	logic nxt_hold_err;
	logic nxt_hold_last;
	logic nxt_in_frame;
	logic [7:0] nxt_txd;
	logic nxt_en;
	logic nxt_er;
	logic pop;

	assign fifo_rd.ready = pop;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_hold = hold_ff;
		nxt_hold_err = hold_err_ff;
		nxt_hold_last = hold_last_ff;
		nxt_in_frame = in_frame_ff;
		nxt_txd = txd_out;
		nxt_en = tx_en_out;
		nxt_er = tx_er_out;
		nxt_mode = mode_ff;
		pop = 1'b0;
		case (st_ff)
			TX_WAIT:
			begin
				if (rise_tick && fifo_rd.valid)
				begin
					pop = 1'b1;
					nxt_hold = pop_byte;
					nxt_hold_err = pop_err;
					nxt_hold_last = pop_last;
					nxt_in_frame = 1'b1;
					nxt_en = 1'b1;
					case (mode_ff)
						MTP_GMII:
						begin
							nxt_txd = pop_byte;
							nxt_er = pop_err;
							nxt_in_frame = !pop_last;
						end
						MTP_RGMII:
						begin
							nxt_txd = {4'h0, pop_byte[3:0]};
							nxt_er = 1'b0;
							nxt_st = TX_DDR_HI;
						end
						default:
						begin
							nxt_txd = {4'h0, pop_byte[3:0]};
							nxt_er = pop_err;
							nxt_st = TX_MII_HI;
						end
					endcase
				end
				else if (rise_tick && in_frame_ff)
				begin
					// Underrun inside a frame: flag a coding error rather than end it early
					nxt_en = 1'b1;
					nxt_txd = TXD_RST;
					if (mode_ff == MTP_RGMII)
					begin
						nxt_er = 1'b0;
						nxt_hold = 8'h00;
						nxt_hold_err = 1'b1;
						nxt_hold_last = 1'b0;
						nxt_st = TX_DDR_HI;
					end
					else
					begin
						nxt_er = 1'b1;
					end
				end
				else if (rise_tick)
				begin
					nxt_en = 1'b0;
					nxt_er = 1'b0;
					nxt_txd = TXD_RST;
				end
				else if (!in_frame_ff)
				begin
					// Mode only moves between frames, never mid-byte
					nxt_mode = want_mode;
				end
			end
			TX_MII_HI:
			begin
				if (mii_rise)
				begin
					nxt_txd = {4'h0, hold_ff[7:4]};
					nxt_en = 1'b1;
					nxt_er = hold_err_ff;
					nxt_in_frame = !hold_last_ff;
					nxt_st = TX_WAIT;
				end
			end
			TX_DDR_HI:
			begin
				if (gen_fall)
				begin
					nxt_txd = {4'h0, hold_ff[7:4]};
					nxt_en = 1'b1 ^ hold_err_ff;
					nxt_er = 1'b0;
					nxt_in_frame = !hold_last_ff;
					nxt_st = TX_WAIT;
				end
			end
			default:
			begin
				nxt_st = TX_WAIT;
			end
		endcase
	end

	// Reference clock watch
	logic ref_prev_ff;
	logic [6:0] ref_cnt_ff;
	logic [6:0] nxt_ref_cnt;

	always_comb
	begin
		// a stopped reference shows as lost
		if (sync_vec[SY_REF] != ref_prev_ff)
			nxt_ref_cnt = '0;
		else if (ref_cnt_ff == REF_WATCH_CYC)
			nxt_ref_cnt = ref_cnt_ff;
		else
			nxt_ref_cnt = 7'(ref_cnt_ff + 1'b1);
	end

	// Side pins
	logic [2:0] gpio_oe_ff;
	logic [2:0] gpio_val_ff;

	assign phy_power_down_pin_out = gpio_val_ff[0];
	assign phy_power_down_pin_oe_out = gpio_oe_ff[0];
	assign aux_gpio_pin_out = gpio_val_ff[2:1];
	assign aux_gpio_pin_oe_out = gpio_oe_ff[2:1];

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			mode_ff <= MTP_MII;
			txclk_prev_ff <= 1'b0;
			div_cnt_ff <= '0;
			div_clk_ff <= 1'b0;
			gtx_clk_out <= 1'b0;
			rgmii_txc_out <= 1'b0;
			st_ff <= TX_WAIT;
			hold_ff <= 8'h00;
			hold_err_ff <= 1'b0;
			hold_last_ff <= 1'b0;
			in_frame_ff <= 1'b0;
			txd_out <= TXD_RST;
			tx_en_out <= 1'b0;
			tx_er_out <= 1'b0;
			tx_busy_out <= 1'b0;
			mode_out <= 2'h0;
			carrier_sense_out <= 1'b0;
			collision_out <= 1'b0;
			ref_prev_ff <= 1'b0;
			ref_cnt_ff <= REF_WATCH_CYC;
			ref_clock_ok_out <= 1'b0;
			phy_reset_out <= 1'b0;
			phy_reset_oe_out <= PHY_RST_OE_RST;
			gpio_oe_ff <= GPIO_OE_RST;
			gpio_val_ff <= GPIO_VAL_RST;
			gpio_state_out <= 3'h0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			txclk_prev_ff <= sync_vec[SY_TXCLK];
			div_cnt_ff <= nxt_div_cnt;
			div_clk_ff <= nxt_div_clk;
			gtx_clk_out <= (mode_ff == MTP_GMII) && nxt_div_clk;
			rgmii_txc_out <= (mode_ff == MTP_RGMII) && nxt_div_clk;
			st_ff <= nxt_st;
			hold_ff <= nxt_hold;
			hold_err_ff <= nxt_hold_err;
			hold_last_ff <= nxt_hold_last;
			in_frame_ff <= nxt_in_frame;
			txd_out <= nxt_txd;
			tx_en_out <= nxt_en;
			tx_er_out <= nxt_er;
			tx_busy_out <= nxt_in_frame || (nxt_st != TX_WAIT);
			mode_out <= nxt_mode;
			carrier_sense_out <= sync_vec[SY_CRS];
			collision_out <= sync_vec[SY_COL];
			ref_prev_ff <= sync_vec[SY_REF];
			ref_cnt_ff <= nxt_ref_cnt;
			ref_clock_ok_out <= (nxt_ref_cnt != REF_WATCH_CYC);
			phy_reset_out <= phy_reset_level_in;
			phy_reset_oe_out <= phy_reset_enable_in;
			gpio_oe_ff <= gpio_dir_out_in;
			gpio_val_ff <= gpio_value_in;
			gpio_state_out <= sync_vec[SY_GPIO +: 3];
		end
	end
endmodule : mtp_tx_port
`default_nettype wire
